/* File: ifd_pkg.sv */
// Shared constants for the instruction field decoder.
package ifd_pkg;

    // Field start positions; bit 0 is the most significant instruction bit.
    localparam int POS_OPCODE = 0;
    localparam int POS_TRAP = 6;
    localparam int POS_FP_MASK = 7;
    localparam int POS_BR_DISP = 6;
    localparam int POS_GPR_FIRST = 11;
    localparam int POS_SEG = 12;
    localparam int POS_SPR = 11;
    localparam int POS_CR_MASK = 12;
    localparam int POS_FP_SRC1 = 11;
    localparam int POS_FP_SRC2 = 16;
    localparam int POS_FP_SRC3 = 21;
    localparam int POS_IMM = 16;
    localparam int POS_STR_CNT = 16;
    localparam int POS_FP_IMM = 16;
    localparam int POS_SVC_WIDE = 16;
    localparam int POS_SVC_INDEX = 20;
    localparam int POS_OV_EN = 21;
    localparam int POS_MASK_START = 21;
    localparam int POS_MASK_STOP = 26;
    localparam int POS_SVC_NARROW = 27;
    localparam int POS_SVC_ABS = 30;
    localparam int POS_LINK = 31;
    localparam int POS_RECORD = 31;

    // Field widths.
    localparam int W_OPCODE = 6;
    localparam int W_REG = 5;
    localparam int W_SEG = 4;
    localparam int W_SPR = 10;
    localparam int W_FP_MASK = 8;
    localparam int W_CR_MASK = 8;
    localparam int W_BR_DISP = 24;
    localparam int W_IMM = 16;
    localparam int W_NIBBLE = 4;
    localparam int W_SVC_INDEX = 7;
    localparam int W_SVC_NARROW = 3;
    localparam int W_SVC_TARGET = 13;

    // Primary operation codes steering the first decode level.
    localparam logic [5:0] OPC_TRAP_IMM = 6'h03;
    localparam logic [5:0] OPC_SVC = 6'h11;
    localparam logic [5:0] OPC_BRANCH = 6'h12;
    localparam logic [5:0] OPC_FX_EXT = 6'h1f;
    localparam logic [5:0] OPC_FP_SINGLE = 6'h3b;
    localparam logic [5:0] OPC_FP_DOUBLE = 6'h3f;

    // Register port map and reset values.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int CTRL_MODE64 = 0;
    localparam logic CTRL_MODE64_RST = 1'b1;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [3:0] INSN_BYTES = 4'h4;

endpackage

/* File: ifd_rotate_mask.sv */
// Rotate mask generator built from a start and a stop index.
module ifd_rotate_mask (
    // Indices, bit 0 being the most significant mask bit.
    input wire logic [4:0] i_start,
    input wire logic [4:0] i_stop,
    // Resulting mask.
    output logic [31:0] o_mask
);

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (i_start <= i_stop) begin
                o_mask[31 - i] = (i >= i_start) && (i <= i_stop);
            end else begin
                // Start above stop wraps; start equal to stop plus one
                // leaves an empty zero run, so the mask is all ones.
                o_mask[31 - i] = !((i > i_stop) && (i < i_start));
            end
        end
    end

endmodule // ifd_rotate_mask

/* File: ifd_decoder.sv */
// Instruction field decoder with registered outputs and a small register port.
module ifd_decoder (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Instruction from fetch.
    input wire logic i_insn_valid,
    input wire logic [31:0] i_insn,
    input wire logic [63:0] i_insn_addr,
    // Execution results and operands.
    input wire logic [63:0] i_fx_result,
    input wire logic i_summary_overflow,
    input wire logic [3:0] i_fp_exceptions,
    input wire logic [63:0] i_trap_a,
    input wire logic [63:0] i_trap_b,
    // Register port.
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_we,
    input wire logic i_reg_re,
    output logic [31:0] o_reg_rdata,
    // Decoded fields.
    output logic o_valid,
    output logic [5:0] o_primary_opcode,
    output logic [4:0] o_first_gpr_operand,
    output logic [3:0] o_segment_register_select,
    output logic [9:0] o_special_register_select,
    output logic [4:0] o_fp_source_one,
    output logic [4:0] o_fp_source_two,
    output logic [4:0] o_fp_source_three,
    output logic [4:0] o_string_byte_count,
    output logic [63:0] o_signed_imm,
    output logic [63:0] o_unsigned_imm,
    output logic [63:0] o_branch_disp,
    output logic [31:0] o_rotate_mask,
    output logic [31:0] o_cr_write_mask,
    output logic [31:0] o_fp_status_write_mask,
    output logic [3:0] o_fp_status_imm,
    // Link, condition, overflow and trap controls.
    output logic o_link_we,
    output logic [63:0] o_link_data,
    output logic o_cr_we,
    output logic [7:0] o_cr_data,
    output logic o_ov_update_en,
    output logic o_trap_taken,
    // Service call controls.
    output logic o_svc_target_valid,
    output logic [12:0] o_svc_target,
    output logic [3:0] o_svc_wide_field,
    output logic [2:0] o_svc_narrow_field
);

    // Field of width w starting at big-endian position p.
    function automatic logic [31:0] fld(input logic [31:0] insn,
                                        input int p, input int w);
        logic [31:0] v;
        v = insn >> (32 - p - w);
        return v & ((32'h1 << w) - 32'h1);
    endfunction

    // Expands an 8-bit field mask, first bit to field 0, into nibbles.
    function automatic logic [31:0] nibble_mask(input logic [7:0] m);
        logic [31:0] r;
        r = 32'h0;
        for (int f = 0; f < 8; f++) begin
            r[31 - 4 * f -: 4] = {4{m[7 - f]}};
        end
        return r;
    endfunction

    logic [31:0] ctrl_q;
    logic [15:0] count_q;
    logic [5:0] opcode;
    logic is_branch;
    logic is_svc;
    logic is_fp;
    logic mode64;
    logic [63:0] next_addr;
    logic [63:0] fx_val;
    logic [63:0] ta;
    logic [63:0] tb;
    logic [4:0] trap_bits;
    logic trap_d;
    logic [3:0] cr_fx;
    logic [31:0] rot_mask;
    logic [63:0] disp64;
    logic [63:0] simm64;

    assign mode64 = ctrl_q[ifd_pkg::CTRL_MODE64];
    assign opcode = 6'(fld(i_insn, ifd_pkg::POS_OPCODE,
                           ifd_pkg::W_OPCODE));
    assign is_branch = opcode == ifd_pkg::OPC_BRANCH;
    assign is_svc = opcode == ifd_pkg::OPC_SVC;
    assign is_fp = (opcode == ifd_pkg::OPC_FP_SINGLE)
        || (opcode == ifd_pkg::OPC_FP_DOUBLE);
    assign next_addr = i_insn_addr + 64'(ifd_pkg::INSN_BYTES);

    // Displacement: 24 bits, two zeros below, sign-extended.
    assign disp64 = {{38{i_insn[25]}}, i_insn[25:2], 2'b00};
    assign simm64 = {{48{i_insn[15]}}, i_insn[15:0]};

    // Comparisons use the low word unless the wide mode is on.
    assign fx_val = mode64 ? i_fx_result
        : {{32{i_fx_result[31]}}, i_fx_result[31:0]};
    assign ta = mode64 ? i_trap_a : {{32{i_trap_a[31]}}, i_trap_a[31:0]};
    assign tb = mode64 ? i_trap_b : {{32{i_trap_b[31]}}, i_trap_b[31:0]};
    assign trap_bits = 5'(fld(i_insn, ifd_pkg::POS_TRAP, ifd_pkg::W_REG));

    // Trap bit k sits at instruction bit 6 + k, so trap_bits[4] is bit 0.
    // Every enabled comparison that holds raises the trap on its own.
    always_comb begin
        trap_d = 1'b0;
        if (trap_bits[4] && ($signed(ta) < $signed(tb))) begin
            trap_d = 1'b1;
        end
        if (trap_bits[3] && ($signed(ta) > $signed(tb))) begin
            trap_d = 1'b1;
        end
        if (trap_bits[2] && (ta == tb)) begin
            trap_d = 1'b1;
        end
        if (trap_bits[1] && (ta < tb)) begin
            trap_d = 1'b1;
        end
        if (trap_bits[0] && (ta > tb)) begin
            trap_d = 1'b1;
        end
    end

    // Less, greater, equal, then the summary overflow copy.
    assign cr_fx = {$signed(fx_val) < 0, $signed(fx_val) > 0,
                    fx_val == 64'h0, i_summary_overflow};

    ifd_rotate_mask u_rotate_mask (
        .i_start(5'(fld(i_insn, ifd_pkg::POS_MASK_START, ifd_pkg::W_REG))),
        .i_stop(5'(fld(i_insn, ifd_pkg::POS_MASK_STOP, ifd_pkg::W_REG))),
        .o_mask(rot_mask)
    );

    // Register port: control is writable, status shows decode history.
    // Read data fall back to zero after their one cycle, so a stale word
    // never lingers; the instruction count wraps silently.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_q <= 32'h0;
            ctrl_q[ifd_pkg::CTRL_MODE64] <= ifd_pkg::CTRL_MODE64_RST;
        end else if (i_reg_we && (i_reg_addr == ifd_pkg::REG_CTRL)) begin
            ctrl_q <= {31'h0, i_reg_wdata[ifd_pkg::CTRL_MODE64]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count_q <= ifd_pkg::COUNT_RST;
        end else if (i_insn_valid) begin
            count_q <= count_q + 16'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 32'h0;
        end else if (i_reg_re) begin
            case (i_reg_addr)
                ifd_pkg::REG_CTRL: o_reg_rdata <= ctrl_q;
                ifd_pkg::REG_STATUS: begin
                    o_reg_rdata <= {count_q, 6'h0, o_cr_we, o_link_we,
                                    2'h0, o_primary_opcode};
                end
                default: o_reg_rdata <= 32'h0;
            endcase
        end else begin
            o_reg_rdata <= 32'h0;
        end
    end

    // Plain field extraction, captured for every valid instruction.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            o_primary_opcode <= 6'h0;
            o_first_gpr_operand <= 5'h0;
            o_segment_register_select <= 4'h0;
            o_special_register_select <= 10'h0;
            o_fp_source_one <= 5'h0;
            o_fp_source_two <= 5'h0;
            o_fp_source_three <= 5'h0;
            o_string_byte_count <= 5'h0;
            o_fp_status_imm <= 4'h0;
        end else begin
            o_valid <= i_insn_valid;
            if (i_insn_valid) begin
                o_primary_opcode <= opcode;
                o_first_gpr_operand <= 5'(fld(i_insn,
                    ifd_pkg::POS_GPR_FIRST, ifd_pkg::W_REG));
                o_segment_register_select <= 4'(fld(i_insn,
                    ifd_pkg::POS_SEG, ifd_pkg::W_SEG));
                o_special_register_select <= 10'(fld(i_insn,
                    ifd_pkg::POS_SPR, ifd_pkg::W_SPR));
                o_fp_source_one <= 5'(fld(i_insn,
                    ifd_pkg::POS_FP_SRC1, ifd_pkg::W_REG));
                o_fp_source_two <= 5'(fld(i_insn,
                    ifd_pkg::POS_FP_SRC2, ifd_pkg::W_REG));
                o_fp_source_three <= 5'(fld(i_insn,
                    ifd_pkg::POS_FP_SRC3, ifd_pkg::W_REG));
                o_string_byte_count <= 5'(fld(i_insn,
                    ifd_pkg::POS_STR_CNT, ifd_pkg::W_REG));
                o_fp_status_imm <= 4'(fld(i_insn,
                    ifd_pkg::POS_FP_IMM, ifd_pkg::W_NIBBLE));
            end
        end
    end

    // Immediates, displacement and masks.
    // In the narrow mode the upper word reads as zero, so a unit that only
    // looks at the low word sees the same value in both modes.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_signed_imm <= 64'h0;
            o_unsigned_imm <= 64'h0;
            o_branch_disp <= 64'h0;
            o_rotate_mask <= 32'h0;
            o_cr_write_mask <= 32'h0;
            o_fp_status_write_mask <= 32'h0;
        end else if (i_insn_valid) begin
            o_signed_imm <= mode64 ? simm64
                : {32'h0, simm64[31:0]};
            o_unsigned_imm <= {48'h0, i_insn[15:0]};
            o_branch_disp <= mode64 ? disp64
                : {32'h0, disp64[31:0]};
            o_rotate_mask <= rot_mask;
            o_cr_write_mask <= nibble_mask(8'(fld(i_insn,
                ifd_pkg::POS_CR_MASK, ifd_pkg::W_CR_MASK)));
            o_fp_status_write_mask <= nibble_mask(8'(fld(i_insn,
                ifd_pkg::POS_FP_MASK, ifd_pkg::W_FP_MASK)));
        end
    end

    // Link register update for branches and service calls.
    // Link and record share the last instruction bit; the opcode decides
    // which meaning applies, so the two write pulses never meet.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_link_we <= 1'b0;
            o_link_data <= 64'h0;
        end else begin
            o_link_we <= i_insn_valid && (is_branch || is_svc)
                && i_insn[31 - ifd_pkg::POS_LINK];
            if (i_insn_valid) begin
                o_link_data <= mode64 ? next_addr
                    : {32'h0, next_addr[31:0]};
            end
        end
    end

    // Condition register update from the record bit.
    // The data are formed for every word; the write pulse alone says
    // whether the condition register takes them.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_cr_we <= 1'b0;
            o_cr_data <= 8'h0;
        end else begin
            o_cr_we <= i_insn_valid && !is_branch && !is_svc
                && i_insn[31 - ifd_pkg::POS_RECORD];
            if (i_insn_valid) begin
                if (is_fp) begin
                    o_cr_data <= {4'h0, i_fp_exceptions};
                end else begin
                    o_cr_data <= {cr_fx, 4'h0};
                end
            end
        end
    end

    // Overflow enable and trap outcome.
    // Both are pulses; the execution units act only in the cycle they stand.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_ov_update_en <= 1'b0;
            o_trap_taken <= 1'b0;
        end else begin
            o_ov_update_en <= i_insn_valid
                && (opcode == ifd_pkg::OPC_FX_EXT)
                && i_insn[31 - ifd_pkg::POS_OV_EN];
            o_trap_taken <= i_insn_valid && trap_d
                && ((opcode == ifd_pkg::OPC_TRAP_IMM)
                || (opcode == ifd_pkg::OPC_FX_EXT));
        end
    end

    // Service call target and pass-through fields.
    // The target is formed for every word; an absolute service call keeps
    // the valid pulse low, so the target is then of no use.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_svc_target_valid <= 1'b0;
            o_svc_target <= 13'h0;
            o_svc_wide_field <= 4'h0;
            o_svc_narrow_field <= 3'h0;
        end else begin
            o_svc_target_valid <= i_insn_valid && is_svc
                && !i_insn[31 - ifd_pkg::POS_SVC_ABS];
            if (i_insn_valid) begin
                o_svc_target <= {1'b1, 7'(fld(i_insn,
                    ifd_pkg::POS_SVC_INDEX, ifd_pkg::W_SVC_INDEX)),
                    5'h00};
                o_svc_wide_field <= 4'(fld(i_insn,
                    ifd_pkg::POS_SVC_WIDE, ifd_pkg::W_NIBBLE));
                o_svc_narrow_field <= 3'(fld(i_insn,
                    ifd_pkg::POS_SVC_NARROW,
                    ifd_pkg::W_SVC_NARROW));
            end
        end
    end

endmodule // ifd_decoder

/* File: ifd_decoder_monitor.sv */
// Concurrent checks on the instruction field decoder ports.
module ifd_decoder_monitor (
    // Clock, reset and instruction.
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_insn_valid,
    input wire logic [31:0] i_insn,
    input wire logic [63:0] i_insn_addr,
    // Decoded outputs.
    input wire logic o_valid,
    input wire logic [5:0] o_primary_opcode,
    input wire logic [3:0] o_segment_register_select,
    input wire logic [63:0] o_branch_disp,
    input wire logic [63:0] o_unsigned_imm,
    input wire logic o_link_we,
    input wire logic [63:0] o_link_data,
    input wire logic o_cr_we,
    input wire logic o_ov_update_en,
    input wire logic o_trap_taken,
    input wire logic o_svc_target_valid,
    input wire logic [12:0] o_svc_target,
    input wire logic [31:0] o_cr_write_mask
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic [31:0] w_q;
    logic [31:0] a_q;
    logic lk_q;
    // Copy of the word that the current outputs were decoded from.
    always_ff @(posedge i_clk) begin
        w_q <= i_insn;
        a_q <= i_insn_addr[31:0];
    end
    assign lk_q = w_q[31:26] == ifd_pkg::OPC_BRANCH ||
        w_q[31:26] == ifd_pkg::OPC_SVC;
    AST_VALID: assert property (i_insn_valid |=> o_valid)
        else $error("valid not answered");
    AST_OPC: assert property (o_valid |->
        o_primary_opcode == w_q[31:26]) else $error("opcode field wrong");
    AST_SEG: assert property (o_valid |->
        o_segment_register_select == w_q[19:16])
        else $error("segment select wrong");
    AST_BDISP: assert property (o_valid |-> o_branch_disp[31:0] ==
        {{6{w_q[25]}}, w_q[25:2], 2'b00}) else $error("displacement wrong");
    AST_UIMM: assert property (o_valid |-> o_unsigned_imm ==
        {48'h0, w_q[15:0]}) else $error("unsigned immediate wrong");
    AST_LINK: assert property (o_valid |->
        o_link_we == (w_q[0] && lk_q)) else $error("link enable wrong");
    AST_LDATA: assert property (o_link_we |->
        o_link_data[31:0] == a_q + 32'h4) else $error("link address wrong");
    AST_CR: assert property (o_valid |->
        o_cr_we == (w_q[0] && !lk_q)) else $error("record enable wrong");
    AST_OV: assert property (o_valid |-> o_ov_update_en ==
        (w_q[31:26] == ifd_pkg::OPC_FX_EXT && w_q[10])) else $error("ov wrong");
    AST_SVCV: assert property (o_valid |-> o_svc_target_valid ==
        (w_q[31:26] == ifd_pkg::OPC_SVC && !w_q[1]))
        else $error("svc valid wrong");
    AST_SVCT: assert property (o_svc_target_valid |->
        o_svc_target == {1'b1, w_q[11:5], 5'h00})
        else $error("svc target wrong");
    AST_CRMASK: assert property (o_valid |->
        o_cr_write_mask[31:28] == {4{w_q[19]}}
        && o_cr_write_mask[3:0] == {4{w_q[12]}})
        else $error("condition mask wrong");
    C_LINK: cover property (o_link_we);
    C_SVC: cover property (o_svc_target_valid);
    C_TRAP: cover property (o_trap_taken);
    C_CR2: cover property (o_cr_we ##1 o_cr_we);
endmodule // ifd_decoder_monitor

bind ifd_decoder ifd_decoder_monitor u_mon (.i_clk, .i_rst_n, .i_insn_valid,
    .i_insn, .i_insn_addr, .o_valid, .o_primary_opcode,
    .o_segment_register_select, .o_branch_disp, .o_unsigned_imm, .o_link_we,
    .o_link_data, .o_cr_we, .o_ov_update_en, .o_trap_taken,
    .o_svc_target_valid, .o_svc_target, .o_cr_write_mask);

/* File: ifd_fetch_model.sv */
// Fetch-side model that presents instruction words to the decoder.
module ifd_fetch_model (
    // Clock and requests from the bench.
    input wire logic i_clk,
    input wire logic i_push,
    input wire logic [31:0] i_word,
    input wire logic [63:0] i_addr,
    // Instruction bus towards the decoder.
    output logic o_valid,
    output logic [31:0] o_insn,
    output logic [63:0] o_insn_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] w_q = '0;
    logic [63:0] a_q = '0;
    always_ff @(posedge i_clk) begin
        if (i_push) begin
            w_q <= i_word;
            a_q <= i_addr;
        end
    end
    // An idle bus shows the inverse of the last word, never a stale copy.
    assign o_valid = i_push;
    assign o_insn = i_push ? i_word : ~w_q;
    assign o_insn_addr = i_push ? i_addr : ~a_q;
endmodule // ifd_fetch_model

/* File: test_instruction_field_decoder.sv */
// Self-checking bench for the instruction field decoder.
module test_instruction_field_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [31:0] w;
        logic [63:0] a, r, ta, tb;
        logic [3:0] fe;
        logic so, m;
    } ifd_tb_req_t;
    logic i_clk = 0, i_rst_n = 0, i_reg_we = 0, i_reg_re = 0, push = 0;
    logic i_summary_overflow = 0, m64 = 1, lk, fp, tt;
    logic [3:0] i_reg_addr = 0, i_fp_exceptions = 0;
    logic [31:0] word = 0, i_reg_wdata = 0;
    logic [63:0] addr = 0, i_fx_result = 0, i_trap_a = 0, i_trap_b = 0;
    logic [63:0] aa, bb, rr;
    wire logic i_insn_valid;
    wire logic [31:0] i_insn;
    wire logic [63:0] i_insn_addr;
    logic o_valid, o_link_we, o_cr_we, o_ov_update_en, o_trap_taken;
    logic o_svc_target_valid;
    logic [31:0] o_reg_rdata, o_rotate_mask, o_cr_write_mask;
    logic [31:0] o_fp_status_write_mask;
    logic [5:0] o_primary_opcode, op, last_op = 0;
    logic [4:0] o_first_gpr_operand, o_fp_source_one, o_fp_source_two;
    logic [4:0] o_fp_source_three, o_string_byte_count;
    logic [3:0] o_segment_register_select, o_fp_status_imm, o_svc_wide_field;
    logic [9:0] o_special_register_select;
    logic [63:0] o_signed_imm, o_unsigned_imm, o_branch_disp, o_link_data;
    logic [7:0] o_cr_data;
    logic [12:0] o_svc_target;
    logic [2:0] o_svc_narrow_field;
    ifd_tb_req_t q[$];
    ifd_tb_req_t x;
    int failures = 0, cmp_count = 0, n = 0;
    logic [5:0] ops[7] = '{ifd_pkg::OPC_TRAP_IMM, ifd_pkg::OPC_SVC,
        ifd_pkg::OPC_BRANCH, ifd_pkg::OPC_FX_EXT, ifd_pkg::OPC_FP_SINGLE,
        ifd_pkg::OPC_FP_DOUBLE, 6'h0e};
    logic [31:0] dir[11] = '{{ifd_pkg::OPC_BRANCH, 24'h800001, 2'b01},
        {ifd_pkg::OPC_BRANCH, 24'h7fffff, 2'b00},
        {ifd_pkg::OPC_SVC, 20'h5a5a5, 6'h01},
        {ifd_pkg::OPC_SVC, 20'ha5a5a, 6'h03},
        {6'h15, 15'h0, 5'h04, 5'h04, 1'b1}, {6'h15, 15'h0, 5'h05, 5'h04, 1'b0},
        {6'h15, 15'h0, 5'h14, 5'h03, 1'b1}, {6'h15, 15'h0, 5'h00, 5'h1f, 1'b0},
        {6'h15, 15'h0, 5'h1f, 5'h00, 1'b0}, {ifd_pkg::OPC_FP_DOUBLE, 26'h1},
        {ifd_pkg::OPC_FX_EXT, 15'h0, 1'b1, 10'h1}};

    always #10 i_clk = ~i_clk;

    ifd_fetch_model u_fetch (.i_clk(i_clk), .i_push(push), .i_word(word),
        .i_addr(addr), .o_valid(i_insn_valid), .o_insn(i_insn),
        .o_insn_addr(i_insn_addr));
    ifd_decoder uut (.*);

    function automatic logic [63:0] sx(input logic [63:0] v, input logic m);
        return m ? v : {{32{v[31]}}, v[31:0]};
    endfunction
    function automatic logic [63:0] md(input logic [63:0] v, input logic m);
        return m ? v : {32'h0, v[31:0]};
    endfunction
    function automatic logic [31:0] rmask(input int s, input int e);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            if (s <= e ? (i >= s && i <= e)
                : (s == e + 1 || i <= e || i >= s))
                r[31 - i] = 1'b1;
        end
        return r;
    endfunction
    function automatic logic [31:0] fmask(input logic [7:0] f);
        logic [31:0] r;
        for (int k = 0; k < 8; k++) r[31 - 4 * k -: 4] = {4{f[7 - k]}};
        return r;
    endfunction

    task automatic check(input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task results;
        $display("Compares %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task send(input logic [31:0] w);
        ifd_tb_req_t t;
        t.w = w;
        t.a = {$urandom, $urandom} & ~64'h3;
        t.r = ($urandom % 4 == 0) ? 64'h0 : {$urandom, $urandom};
        t.ta = {$urandom, $urandom};
        t.tb = ($urandom % 4 == 0) ? t.ta : {$urandom, $urandom};
        t.fe = 4'($urandom);
        t.so = 1'($urandom);
        t.m = m64;
        @(posedge i_clk);
        push <= 1;
        word <= w;
        addr <= t.a;
        i_fx_result <= t.r;
        i_trap_a <= t.ta;
        i_trap_b <= t.tb;
        i_fp_exceptions <= t.fe;
        i_summary_overflow <= t.so;
        q.push_back(t);
        n++;
        last_op = w[31:26];
    endtask
    task burst(input int c);
        logic [31:0] w;
        repeat (c) begin
            w = $urandom;
            w[31:26] = ops[$urandom % 7];
            send(w);
        end
    endtask
    task idle;
        @(posedge i_clk);
        push <= 0;
        for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge i_clk);
        if (q.size() > 0) begin
            failures++;
            results();
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_we <= 1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_we <= 0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_reg_re <= 1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_re <= 0;
        @(negedge i_clk);
        check(o_reg_rdata, e);
    endtask

    // Every decoded word is compared against the queued request.
    always @(negedge i_clk) begin
        if (o_valid === 1'b1 && q.size() == 0) check(1, 0);
        else if (o_valid === 1'b1) begin
            x = q.pop_front();
            op = x.w[31:26];
            lk = op == ifd_pkg::OPC_BRANCH || op == ifd_pkg::OPC_SVC;
            fp = op == ifd_pkg::OPC_FP_SINGLE || op == ifd_pkg::OPC_FP_DOUBLE;
            rr = sx(x.r, x.m);
            aa = sx(x.ta, x.m);
            bb = sx(x.tb, x.m);
            tt = (x.w[25] && $signed(aa) < $signed(bb)) ||
                (x.w[24] && $signed(aa) > $signed(bb)) ||
                (x.w[23] && aa == bb) ||
                (x.w[22] && aa < bb) || (x.w[21] && aa > bb);
            check(o_primary_opcode, op);
            check(o_first_gpr_operand, x.w[20:16]);
            check(o_segment_register_select, x.w[19:16]);
            check(o_special_register_select, x.w[20:11]);
            check({o_fp_source_one, o_fp_source_two,
                o_fp_source_three}, x.w[20:6]);
            check(o_string_byte_count, x.w[15:11]);
            check(o_fp_status_imm, x.w[15:12]);
            check(o_signed_imm,
                md({{48{x.w[15]}}, x.w[15:0]}, x.m));
            check(o_unsigned_imm, {48'h0, x.w[15:0]});
            check(o_branch_disp,
                md({{38{x.w[25]}}, x.w[25:2], 2'b00}, x.m));
            check(o_rotate_mask, rmask(x.w[10:6], x.w[5:1]));
            check(o_cr_write_mask, fmask(x.w[19:12]));
            check(o_fp_status_write_mask, fmask(x.w[24:17]));
            check(o_link_we, lk && x.w[0]);
            if (lk && x.w[0])
                check(o_link_data, md(x.a + 64'h4, x.m));
            check(o_cr_we, !lk && x.w[0]);
            if (!lk && x.w[0])
                check(o_cr_data, fp ? {4'h0, x.fe} :
                    {$signed(rr) < 0, $signed(rr) > 0, rr == 0, x.so, 4'h0});
            check(o_ov_update_en,
                op == ifd_pkg::OPC_FX_EXT && x.w[10]);
            check(o_trap_taken, tt &&
                (op == ifd_pkg::OPC_TRAP_IMM || op == ifd_pkg::OPC_FX_EXT));
            check(o_svc_target_valid,
                op == ifd_pkg::OPC_SVC && !x.w[1]);
            if (op == ifd_pkg::OPC_SVC && !x.w[1])
                check(o_svc_target, {1'b1, x.w[11:5], 5'h00});
            check({o_svc_wide_field, o_svc_narrow_field},
                {x.w[15:12], x.w[4:2]});
        end
    end

    initial begin
        void'($urandom(32'h302e4ad3));
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1;
        rd(ifd_pkg::REG_CTRL, 32'h1);
        rd(ifd_pkg::REG_STATUS, 32'h0);
        rd(4'h8, 32'h0);
        foreach (dir[i]) send(dir[i]);
        for (int k = 0; k < 5; k++) begin
            repeat (4) begin
                send({ifd_pkg::OPC_TRAP_IMM, 5'h10 >> k, 21'($urandom)});
            end
        end
        burst(200);
        idle();
        rd(ifd_pkg::REG_STATUS, {16'(n), 10'h0, last_op});
        wr(ifd_pkg::REG_STATUS, 32'hffffffff);
        rd(ifd_pkg::REG_STATUS, {16'(n), 10'h0, last_op});
        wr(ifd_pkg::REG_CTRL, 32'h0);
        m64 = 0;
        rd(ifd_pkg::REG_CTRL, 32'h0);
        foreach (dir[i]) send(dir[i]);
        burst(100);
        idle();
        results();
    end
endmodule // test_instruction_field_decoder
